// ===== ch2_prot_params.svh
// Offsets, field positions, reset values and timing counts for the channel-2 protection block.
`ifndef CH2_PROT_PARAMS_SVH
`define CH2_PROT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define CH2_ADDR_W 8
`define CH2_VDS_RESULT_OFFSET 8'h1d
`define CH2_PROT_CONFIG_OFFSET 8'h1e
`define CH2_VDS_RESULT_RESET 16'hf800
`define CH2_PROT_CONFIG_RESET 16'h0000
`define CH2_VDS_RSVD_FILL 5'h1f
`define CH2_CONFIG_WR_MASK 16'hc7ff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VDS_FRESH_BIT 10
`define VDS_VALUE_MSB 9
`define VDS_VALUE_W 10
`define COOL_SEL_MSB 15
`define COOL_SEL_LSB 14
`define DLY_SEL_MSB 10
`define DLY_SEL_LSB 9
`define CUR_SEL_MSB 8
`define CUR_SEL_LSB 7
`define TRIP_MSB 6
`define TRIP_LSB 3
`define NOM_MSB 2
`define NOM_LSB 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CORE_CLK_HZ 20000000.0
`define OC_DLY0_MS 0.2
`define OC_DLY1_MS 0.4
`define OC_DLY2_MS 1.0
`define OC_DLY3_MS 2.0
`define COOL1_S 0.8
`define COOL2_S 2.0
`define COOL3_S 4.0
`define MS_TO_CYC(t) $rtoi($ceil((t) * `CORE_CLK_HZ / 1000.0))
`define S_TO_CYC(t) $rtoi($ceil((t) * `CORE_CLK_HZ))
`define OC_CNT_W 16
`define COOL_CNT_W 27

`endif

// ===== ch2_prot_pkg.sv
// Types shared by the channel-2 protection block.
`include "ch2_prot_params.svh"
package ch2_prot_pkg;

  typedef enum logic [1:0] {COOL_IDLE, COOL_HOLD, COOL_RUN} cool_state_t;

  typedef struct packed {
    logic over_meta;
    logic over_sync;
    logic [`VDS_VALUE_W-1:0] vds_value;
    logic vds_fresh;
    logic [15:0] cfg;
    cool_state_t cool;
    logic [`COOL_CNT_W-1:0] cool_cnt;
    logic retry;
    logic [15:0] rdata;
  } prot_state_t;

  typedef struct packed {
    logic [`OC_CNT_W-1:0] cnt;
    logic fired;
    logic trip;
  } oc_timer_state_t;

endpackage : ch2_prot_pkg

// ===== oc_delay_timer.sv
// Overcurrent persistence timer for channel 2.
`timescale 1ns/1ps
`include "ch2_prot_params.svh"
module oc_delay_timer #(
  parameter int unsigned D0_CYC = 4000,
  parameter int unsigned D1_CYC = 8000,
  parameter int unsigned D2_CYC = 20000,
  parameter int unsigned D3_CYC = 40000
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic over_i,
  input wire logic [1:0] sel_i,
  output logic trip_o
);

  ch2_prot_pkg::oc_timer_state_t st;
  ch2_prot_pkg::oc_timer_state_t next_st;
  logic [`OC_CNT_W-1:0] lim;

  // --------------------------------------------------------------------------
  // Timer
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (sel_i) // [R6]
      2'h0: lim = `OC_CNT_W'(D0_CYC);
      2'h1: lim = `OC_CNT_W'(D1_CYC);
      2'h2: lim = `OC_CNT_W'(D2_CYC);
      2'h3: lim = `OC_CNT_W'(D3_CYC);
    endcase
  end

  // Any dip below the threshold restarts the count, so only a continuous excess trips.
  always_comb begin
    next_st = st;
    next_st.trip = 1'b0;
    if (!over_i) begin // [R7]
      next_st.cnt = '0;
      next_st.fired = 1'b0;
    end else if (!st.fired) begin
      if (st.cnt >= lim - `OC_CNT_W'(1)) begin // [R7]
        next_st.fired = 1'b1;
        next_st.trip = 1'b1;
      end else begin
        next_st.cnt = st.cnt + `OC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign trip_o = st.trip;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_oc_trip_at_limit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && over_i && !st.fired && st.cnt == lim - `OC_CNT_W'(1) |=> trip_o;
  endproperty
  a_oc_trip_at_limit: assert property (p_oc_trip_at_limit) else $error("no trip at limit"); // [R7]

  property p_oc_drop_resets;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !over_i |=> st.cnt == '0 && !trip_o;
  endproperty
  a_oc_drop_resets: assert property (p_oc_drop_resets) else $error("dip did not reset"); // [R7]

  property p_oc_trip_needs_count;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(trip_o) |-> $past(st.cnt) == $past(lim) - `OC_CNT_W'(1) && $past(over_i);
  endproperty
  a_oc_trip_needs_count: assert property (p_oc_trip_needs_count) else $error("early trip"); // [R6]

  c_oc_trip: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) trip_o);

endmodule : oc_delay_timer

// ===== ch2_vds_readout_overcurrent_cooldown.sv
// Channel-2 drain-source result register, overcurrent delay and cool-down control.
`timescale 1ns/1ps
`include "ch2_prot_params.svh"
// Function
// [R1] Fresh flag set on each new conversion.
// [R2] Result register carries 10-bit conversion in 9:0.
// [R3] Cool-down codes: indefinite, 0.8, 2.0, 4.0 s.
// [R4] Indefinite code: stay off, never retry alone.
// [R5] Host rewrites finite code to restart channel.
// [R6] Delay codes: 0.2, 0.4, 1.0, 2.0 ms.
// [R7] Off only if current stays above for delay.
// [R8] Threshold codes select 19.55/17.6/16.05/13.3 A.
// [R9] Read clears fresh flag; writes leave it.
// [R10] Fuse trip and nominal fields locked in cool-down.
module ch2_vds_readout_overcurrent_cooldown #(
  parameter int unsigned OC_DLY0_CYC = `MS_TO_CYC(`OC_DLY0_MS),
  parameter int unsigned OC_DLY1_CYC = `MS_TO_CYC(`OC_DLY1_MS),
  parameter int unsigned OC_DLY2_CYC = `MS_TO_CYC(`OC_DLY2_MS),
  parameter int unsigned OC_DLY3_CYC = `MS_TO_CYC(`OC_DLY3_MS),
  parameter int unsigned COOL1_CYC = `S_TO_CYC(`COOL1_S),
  parameter int unsigned COOL2_CYC = `S_TO_CYC(`COOL2_S),
  parameter int unsigned COOL3_CYC = `S_TO_CYC(`COOL3_S)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [`CH2_ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic vds_valid_i,
  input wire logic [`VDS_VALUE_W-1:0] vds_value_i,
  input wire logic over_threshold_i,
  input wire logic fuse_trip_i,
  output logic [1:0] ch2_delayed_off_current_select_o,
  output logic [3:0] ch2_fuse_trip_level_o,
  output logic [2:0] ch2_fuse_nominal_current_o,
  output logic ch2_overcurrent_off_o,
  output logic ch2_fuse_off_o,
  output logic ch2_fuse_retry_o
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  localparam longint unsigned COOL_MAX = 64'd1 << `COOL_CNT_W;
  localparam longint unsigned OC_MAX = 64'd1 << `OC_CNT_W;

  if (COOL1_CYC < 1 || COOL2_CYC < 1 || COOL3_CYC < 1 ||
      COOL1_CYC >= COOL_MAX || COOL2_CYC >= COOL_MAX || COOL3_CYC >= COOL_MAX) begin : g_bad_cool
    $error("cool-down count out of range");
  end
  if (OC_DLY0_CYC < 1 || OC_DLY1_CYC < 1 || OC_DLY2_CYC < 1 || OC_DLY3_CYC < 1 ||
      OC_DLY0_CYC >= OC_MAX || OC_DLY1_CYC >= OC_MAX || OC_DLY2_CYC >= OC_MAX ||
      OC_DLY3_CYC >= OC_MAX) begin : g_bad_oc
    $error("overcurrent delay count out of range");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ch2_prot_pkg::prot_state_t st;
  ch2_prot_pkg::prot_state_t next_st;
  logic [1:0] cool_sel;
  logic [`COOL_CNT_W-1:0] cool_lim;
  logic rd_vds;
  logic wr_cfg;
  logic [15:0] cfg_wr;

  assign cool_sel = st.cfg[`COOL_SEL_MSB:`COOL_SEL_LSB];
  assign rd_vds = reg_rd_i && reg_addr_i == `CH2_VDS_RESULT_OFFSET;
  assign wr_cfg = reg_wr_i && reg_addr_i == `CH2_PROT_CONFIG_OFFSET;

  always_comb begin
    unique case (cool_sel) // [R3]
      2'h0: cool_lim = '0;
      2'h1: cool_lim = `COOL_CNT_W'(COOL1_CYC);
      2'h2: cool_lim = `COOL_CNT_W'(COOL2_CYC);
      2'h3: cool_lim = `COOL_CNT_W'(COOL3_CYC);
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.retry = 1'b0;
    // The comparator output is asynchronous to the core clock.
    next_st.over_meta = over_threshold_i;
    next_st.over_sync = st.over_meta;

    // Read data is captured before the flag clears, so a read sees the flag it clears.
    next_st.rdata = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == `CH2_VDS_RESULT_OFFSET) begin
        next_st.rdata = {`CH2_VDS_RSVD_FILL, st.vds_fresh, st.vds_value}; // [R2]
      end else if (reg_addr_i == `CH2_PROT_CONFIG_OFFSET) begin
        next_st.rdata = st.cfg;
      end
    end

    if (rd_vds) begin
      next_st.vds_fresh = 1'b0; // [R9]
    end
    // A result landing in the cycle of the read wins over the clear.
    if (vds_valid_i) begin
      next_st.vds_value = vds_value_i; // [R2]
      next_st.vds_fresh = 1'b1; // [R1]
    end

    cfg_wr = reg_wdata_i & `CH2_CONFIG_WR_MASK;
    if (st.cool != ch2_prot_pkg::COOL_IDLE) begin
      cfg_wr[`TRIP_MSB:`NOM_LSB] = st.cfg[`TRIP_MSB:`NOM_LSB]; // [R10]
    end
    if (wr_cfg) begin
      next_st.cfg = cfg_wr; // [R8]
    end

    unique case (st.cool)
      ch2_prot_pkg::COOL_IDLE: begin
        if (fuse_trip_i) begin
          next_st.cool_cnt = '0;
          next_st.cool = (cool_sel == 2'h0) ? ch2_prot_pkg::COOL_HOLD
                                            : ch2_prot_pkg::COOL_RUN; // [R4]
        end
      end
      ch2_prot_pkg::COOL_HOLD: begin
        if (cool_sel != 2'h0) begin
          next_st.cool = ch2_prot_pkg::COOL_RUN; // [R5]
          next_st.cool_cnt = '0;
        end
      end
      ch2_prot_pkg::COOL_RUN: begin
        if (cool_sel == 2'h0) begin
          next_st.cool = ch2_prot_pkg::COOL_HOLD; // [R4]
        end else if (st.cool_cnt >= cool_lim - `COOL_CNT_W'(1)) begin
          next_st.cool = ch2_prot_pkg::COOL_IDLE; // [R3]
          next_st.retry = 1'b1;
        end else begin
          next_st.cool_cnt = st.cool_cnt + `COOL_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '{over_meta: 1'b0, over_sync: 1'b0, vds_value: '0, vds_fresh: 1'b0,
              cfg: `CH2_PROT_CONFIG_RESET, cool: ch2_prot_pkg::COOL_IDLE,
              cool_cnt: '0, retry: 1'b0, rdata: 16'h0000};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Overcurrent timer
  // --------------------------------------------------------------------------
  oc_delay_timer #(
    .D0_CYC(OC_DLY0_CYC),
    .D1_CYC(OC_DLY1_CYC),
    .D2_CYC(OC_DLY2_CYC),
    .D3_CYC(OC_DLY3_CYC)
  ) u_oc_delay_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .over_i(st.over_sync),
    .sel_i(st.cfg[`DLY_SEL_MSB:`DLY_SEL_LSB]),
    .trip_o(ch2_overcurrent_off_o)
  );

  assign reg_rdata_o = st.rdata;
  assign ch2_delayed_off_current_select_o = st.cfg[`CUR_SEL_MSB:`CUR_SEL_LSB]; // [R8]
  assign ch2_fuse_trip_level_o = st.cfg[`TRIP_MSB:`TRIP_LSB];
  assign ch2_fuse_nominal_current_o = st.cfg[`NOM_MSB:`NOM_LSB];
  assign ch2_fuse_off_o = st.cool != ch2_prot_pkg::COOL_IDLE;
  assign ch2_fuse_retry_o = st.retry;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_fresh_set;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && vds_valid_i |=> st.vds_fresh && st.vds_value == $past(vds_value_i);
  endproperty
  a_fresh_set: assert property (p_fresh_set) else $error("fresh flag not set"); // [R1]

  property p_fresh_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rd_vds && !vds_valid_i |=> !st.vds_fresh;
  endproperty
  a_fresh_clear: assert property (p_fresh_clear) else $error("read did not clear flag"); // [R9]

  property p_fresh_write_keeps;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && reg_wr_i && !reg_rd_i && !vds_valid_i |=> $stable(st.vds_fresh);
  endproperty
  a_fresh_write_keeps: assert property (p_fresh_write_keeps) else $error("write moved flag"); // [R9]

  property p_vds_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rd_vds |=> reg_rdata_o == {`CH2_VDS_RSVD_FILL, $past(st.vds_fresh), $past(st.vds_value)};
  endproperty
  a_vds_read: assert property (p_vds_read) else $error("bad result read"); // [R2]

  property p_indef_entry;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.cool == ch2_prot_pkg::COOL_IDLE && fuse_trip_i && cool_sel == 2'h0
    |=> st.cool == ch2_prot_pkg::COOL_HOLD ##1 ch2_fuse_off_o;
  endproperty
  a_indef_entry: assert property (p_indef_entry) else $error("indefinite not held"); // [R4]

  property p_no_retry_from_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(ch2_fuse_retry_o)
    |-> $past(st.cool) == ch2_prot_pkg::COOL_RUN && $past(cool_sel) != 2'h0;
  endproperty
  a_no_retry_from_hold: assert property (p_no_retry_from_hold) else $error("retry w/o timer"); // [R4]

  property p_rewrite_restart;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.cool == ch2_prot_pkg::COOL_HOLD && cool_sel != 2'h0
    |=> st.cool == ch2_prot_pkg::COOL_RUN && st.cool_cnt == '0;
  endproperty
  a_rewrite_restart: assert property (p_rewrite_restart) else $error("no restart"); // [R5]

  property p_retry_at_limit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.cool == ch2_prot_pkg::COOL_RUN && cool_sel != 2'h0 &&
    st.cool_cnt == cool_lim - `COOL_CNT_W'(1) |=> ch2_fuse_retry_o && !ch2_fuse_off_o;
  endproperty
  a_retry_at_limit: assert property (p_retry_at_limit) else $error("retry not at limit"); // [R3]

  property p_fuse_fields_locked;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && ch2_fuse_off_o && wr_cfg
    |=> $stable(ch2_fuse_trip_level_o) && $stable(ch2_fuse_nominal_current_o);
  endproperty
  a_fuse_fields_locked: assert property (p_fuse_fields_locked) else $error("fields changed"); // [R10]

  property p_cur_sel_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && wr_cfg |=> ch2_delayed_off_current_select_o == $past(reg_wdata_i[8:7]);
  endproperty
  a_cur_sel_write: assert property (p_cur_sel_write) else $error("threshold not stored"); // [R8]

  c_fresh_read: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.vds_fresh && rd_vds);
  c_fuse_retry: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ch2_fuse_retry_o);
  c_hold_restart: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.cool == ch2_prot_pkg::COOL_HOLD ##1 st.cool == ch2_prot_pkg::COOL_RUN);

endmodule : ch2_vds_readout_overcurrent_cooldown

// ===== ch2_host_model.sv
// Host model that drives the register strobe port of channel-2 protection.
`timescale 1ns/1ps
`include "ch2_prot_params.svh"
module ch2_host_model (
  input wire logic core_clk_i,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [`CH2_ADDR_W-1:0] reg_addr_o,
  output logic [15:0] reg_wdata_o
);
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
  end

  // Released address and data show the inverse, so stale values never look valid.
  task automatic write(input logic [`CH2_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : write

  task automatic read(input logic [`CH2_ADDR_W-1:0] a);
    @(posedge core_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask : read

  // Fuse settings are only sent with the cool-down code; they are not trusted while held off.
  task automatic restart(input logic [1:0] code, input logic [13:0] rest);
    write(`CH2_PROT_CONFIG_OFFSET, {code, rest});
  endtask : restart
endmodule : ch2_host_model

// ===== ch2_vds_readout_overcurrent_cooldown_test.sv
// Self-checking testbench for the channel-2 result and protection block.
`timescale 1ns/1ps
`include "ch2_prot_params.svh"
module ch2_vds_readout_overcurrent_cooldown_test;
  localparam int unsigned OC[4] = '{4, 10, 16, 22};
  localparam int unsigned COOL[4] = '{0, 5, 10, 15};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic rd, wr, vds_valid, over, fuse, oc_off, f_off, retry, rd_d;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [9:0] vds_value, v;
  logic [1:0] cur_sel;
  logic [3:0] trip_lvl;
  logic [2:0] nom;
  logic [15:0] exp_q[$];
  integer mismatches = 0;
  integer checked = 0;
  integer cycles = 0;
  integer seed, n, i;

  ch2_vds_readout_overcurrent_cooldown #(.OC_DLY0_CYC(OC[0]), .OC_DLY1_CYC(OC[1]),
    .OC_DLY2_CYC(OC[2]), .OC_DLY3_CYC(OC[3]), .COOL1_CYC(COOL[1]), .COOL2_CYC(COOL[2]),
    .COOL3_CYC(COOL[3])) ch2_vds_readout_overcurrent_cooldown_i (.core_clk_i(core_clk),
    .rst_n_i(rst_n), .ce_i(ce), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .vds_valid_i(vds_valid),
    .vds_value_i(vds_value), .over_threshold_i(over), .fuse_trip_i(fuse),
    .ch2_delayed_off_current_select_o(cur_sel), .ch2_fuse_trip_level_o(trip_lvl),
    .ch2_fuse_nominal_current_o(nom), .ch2_overcurrent_off_o(oc_off),
    .ch2_fuse_off_o(f_off), .ch2_fuse_retry_o(retry));

  ch2_host_model ch2_host_model_i (.core_clk_i(core_clk), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_wdata_o(wdata));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    checked = checked + 1;
    if (got !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, got);
      mismatches = mismatches + 1;
    end
  endtask : chk

  task test_done;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Read data is registered, so the note is compared one edge after the strobe.
  initial rd_d = 1'b0;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (rd_d && exp_q.size() > 0) begin
      chk("reg_rdata_o", exp_q.pop_front(), rdata);
    end
    rd_d = rd;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------------
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    ch2_host_model_i.read(a);
  endtask : rdx

  task automatic count(input bit use_retry, input int lim, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k = k + 1;
    end while (((use_retry ? retry : oc_off) !== 1'b1) && k < lim);
  endtask : count

  task automatic trip_fuse;
    @(posedge core_clk);
    fuse <= 1'b1;
    @(posedge core_clk);
    fuse <= 1'b0;
    @(posedge core_clk);
    chk("ch2_fuse_off_o", 16'h1, {15'h0, f_off});
  endtask : trip_fuse

  initial begin
    seed = 32'hf5c2;
    {vds_valid, over, fuse} = 3'b000;
    vds_value = 10'h000;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // While the clock enable is low, a write and a result must both be ignored.
    ce <= 1'b0;
    ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, 16'hffff);
    vds_valid <= 1'b1;
    vds_value <= 10'h3ff;
    @(posedge core_clk);
    vds_valid <= 1'b0;
    ce <= 1'b1;
    rdx(`CH2_VDS_RESULT_OFFSET, `CH2_VDS_RESULT_RESET);
    rdx(`CH2_PROT_CONFIG_OFFSET, `CH2_PROT_CONFIG_RESET);
    rdx(8'h40, 16'h0000);
    v = 10'($random(seed));
    @(posedge core_clk);
    vds_valid <= 1'b1;
    vds_value <= v;
    @(posedge core_clk);
    vds_valid <= 1'b0;
    vds_value <= ~v;
    rdx(`CH2_VDS_RESULT_OFFSET, {`CH2_VDS_RSVD_FILL, 1'b1, v});
    // A result that lands with a read must survive the clear of that read.
    fork
      rdx(`CH2_VDS_RESULT_OFFSET, {`CH2_VDS_RSVD_FILL, 1'b0, v});
      begin
        @(posedge core_clk);
        vds_valid <= 1'b1;
        @(posedge core_clk);
        vds_valid <= 1'b0;
      end
    join
    ch2_host_model_i.write(`CH2_VDS_RESULT_OFFSET, 16'hffff);
    rdx(`CH2_VDS_RESULT_OFFSET, {`CH2_VDS_RSVD_FILL, 1'b1, ~v});
    rdx(`CH2_VDS_RESULT_OFFSET, {`CH2_VDS_RSVD_FILL, 1'b0, ~v});
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      d[8:7] = 2'(i);
      ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, d);
      @(posedge core_clk);
      chk("ch2_delayed_off_current_select_o", 16'(i), {14'h0, cur_sel});
      rdx(`CH2_PROT_CONFIG_OFFSET, d & `CH2_CONFIG_WR_MASK);
    end
    for (i = 0; i < 4; i++) begin
      ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, {5'h00, 2'(i), 9'h000});
      @(posedge core_clk);
      over <= 1'b1;
      count(1'b0, 40, n);
      over <= 1'b0;
      chk("overcurrent delay", 16'h1, 16'(n >= OC[i] + 2 && n <= OC[i] + 5));
    end
    // A run one sample short of the longest delay must not turn the channel off.
    @(posedge core_clk);
    over <= 1'b1;
    repeat (OC[3] - 1) @(posedge core_clk);
    over <= 1'b0;
    count(1'b0, 30, n);
    chk("short overcurrent", 16'h0, 16'(n < 30));
    for (i = 1; i < 4; i++) begin
      ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, {2'(i), 14'h0000});
      trip_fuse();
      count(1'b1, 40, n);
      chk("cool-down time", 16'h1, 16'(n + 1 >= COOL[i] && n <= COOL[i] + 2));
      chk("ch2_fuse_off_o", 16'h0, {15'h0, f_off});
    end
    ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, 16'h0000);
    trip_fuse();
    count(1'b1, 40, n);
    chk("indefinite retry", 16'h0, 16'(n < 40));
    chk("ch2_fuse_off_o", 16'h1, {15'h0, f_off});
    ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, 16'h0028);
    @(posedge core_clk);
    chk("ch2_fuse_trip_level_o", 16'h0, {12'h000, trip_lvl});
    ch2_host_model_i.restart(2'b01, 14'h0028);
    count(1'b1, COOL[1] + 6, n);
    chk("retry after rewrite", 16'h1, 16'(n < COOL[1] + 6));
    ch2_host_model_i.write(`CH2_PROT_CONFIG_OFFSET, 16'h402d);
    @(posedge core_clk);
    chk("ch2_fuse_trip_level_o", 16'h5, {12'h000, trip_lvl});
    chk("ch2_fuse_nominal_current_o", 16'h5, {13'h0000, nom});
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule : ch2_vds_readout_overcurrent_cooldown_test
